// *** bench/flr_chk.sv ***
// Port checker for the fault log bank.
// Bound into flr_fault_log; sees its ports only.
module flr_chk #(
	parameter int STEP_CYCLES = 10
) (
	input wire logic        i_sys_clk,
	input wire logic        i_reset_n,
	input wire logic        i_shutdown,
	input wire logic        i_startup,
	input wire logic [7:0]  i_cmd,
	input wire logic        i_wr_stb,
	input wire logic        i_rd_stb,
	input wire logic [15:0] o_rd_data,
	input wire logic        o_rd_valid,
	input wire logic        o_wr_reject,
	input wire logic        o_acc_running,
	input wire logic        o_first_fault_seen
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_date_wr;
		i_wr_stb && i_cmd == flr_pkg::CMD_DATE_WORD;
	endsequence
	rd_answer_a: assert property (i_rd_stb |=> o_rd_valid)
		else $error("read not answered");
	other_reject_a: assert property (i_wr_stb && !(i_cmd inside {[8'hE0:8'hE2]}) |=> o_wr_reject)
		else $error("write not refused");
	sec_accept_a: assert property (i_wr_stb && i_cmd inside {[8'hE1:8'hE2]} |=> !o_wr_reject)
		else $error("time cell write refused");
	first_hold_a: assert property (o_first_fault_seen && !i_shutdown |=> o_first_fault_seen)
		else $error("first fault record lost");
	date_reject_a: assert property (s_date_wr ##0 o_acc_running |=> o_wr_reject)
		else $error("date write kept while running");
	date_accept_a: assert property (s_date_wr ##0 !o_acc_running |=> !o_wr_reject)
		else $error("date write refused while idle");
	upper_zero_a: assert property (i_rd_stb && i_cmd == flr_pkg::CMD_SEC_UPPER |=> o_rd_data[15:8] == 8'h00)
		else $error("upper byte not zero");
	snap_zero_a: assert property (i_rd_stb && i_cmd inside {[8'hE3:8'hE6]} |=> o_rd_data[15:10] == 6'h00)
		else $error("snapshot top bits not zero");
	acc_start_a: assert property (i_startup && !i_shutdown |=> o_acc_running)
		else $error("accumulator not started");
	shut_stop_a: assert property (i_shutdown |=> !o_acc_running)
		else $error("accumulator runs after shutdown");
endmodule

bind flr_fault_log flr_chk #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.i_sys_clk, .i_reset_n, .i_shutdown,
	.i_startup, .i_cmd, .i_wr_stb, .i_rd_stb, .o_rd_data, .o_rd_valid, .o_wr_reject, .o_acc_running,
	.o_first_fault_seen);

// *** bench/flr_host.sv ***
// Management host model: single-cycle command strobes.
// Assumes strobes are taken on the rising clock edge.
module flr_host (
	input  wire logic        i_sys_clk,
	input  wire logic [15:0] i_rd_data,
	output logic      [7:0]  o_cmd,
	output logic             o_wr_stb,
	output logic             o_rd_stb,
	output logic      [15:0] o_wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_cmd = 8'h00;
		o_wr_stb = 1'b0;
		o_rd_stb = 1'b0;
		o_wr_data = 16'h0000;
	end
	// Writes always carry a whole 16-bit word
	task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] wd, output logic [15:0] rd);
		@(posedge i_sys_clk);
		#1;
		o_cmd = c;
		o_wr_data = wd;
		o_wr_stb = wr;
		o_rd_stb = !wr;
		@(posedge i_sys_clk);
		#1;
		o_wr_stb = 1'b0;
		o_rd_stb = 1'b0;
		o_cmd = ~c;
		o_wr_data = ~wd;
		rd = i_rd_data;
	endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the fault log bank.
// Assumes flr_chk is bound in and flr_host drives commands.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STEP = 10;
	logic        clk, rst_n, bwr, brd, run, ffs;
	logic [3:0]  ev;
	logic [63:0] codes, first;
	logic [9:0]  m [4];
	logic [9:0]  snap [4];
	logic [7:0]  bcmd;
	logic [15:0] bwd, rdat, nvm_d, wd, d, e, f;
	logic [31:0] seed = 32'h44;
	int          mismatches, n_tests, cyc;
	flr_fault_log #(.STEP_CYCLES(STEP)) dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_shutdown(ev[0]),
		.i_startup(ev[1]), .i_fault_event(ev[2]), .i_phase_codes(codes), .i_rail1_current_monitor(m[0]),
		.i_rail2_current_monitor(m[1]), .i_rail1_diff_voltage(m[2]), .i_rail2_diff_voltage(m[3]),
		.i_cmd(bcmd), .i_wr_stb(bwr), .i_rd_stb(brd), .i_wr_data(bwd), .i_nvm_date_load(ev[3]),
		.i_nvm_date(nvm_d), .o_rd_data(rdat), .o_rd_valid(), .o_wr_reject(), .o_acc_running(run),
		.o_first_fault_seen(ffs));
	flr_host host (.i_sys_clk(clk), .i_rd_data(rdat), .o_cmd(bcmd), .o_wr_stb(bwr), .o_rd_stb(brd),
		.o_wr_data(bwd));
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] pw(input logic [7:0] c, input logic [63:0] x);
		if (c == flr_pkg::CMD_PHASE_R1_HI_A)
			return {x[35:32], x[39:36], x[43:40], x[47:44]};
		if (c == flr_pkg::CMD_PHASE_R1_HI_B)
			return {x[51:48], x[55:52], x[59:56], x[63:60]};
		return x[15:0];
	endfunction
	task automatic chk(input logic [15:0] s, input logic [15:0] x);
		n_tests++;
		if (s !== x) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, x);
		end
	endtask
	task automatic rc(input logic [7:0] c, input logic [15:0] x);
		host.xfer(1'b0, c, 16'h0000, d);
		chk(d, x);
	endtask
	task automatic pulse(input logic [3:0] p);
		@(posedge clk);
		#1;
		ev = p;
		@(posedge clk);
		#1;
		ev = 4'h0;
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			finish_test();
		end
	end
	initial begin
		rst_n = 1'b0;
		ev = 4'h0;
		codes = 64'h0;
		nvm_d = 16'h0000;
		m = '{default: 10'h000};
		repeat (16) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge clk);
		for (int c = 8'hDD; c <= 8'hE7; c++) rc(8'(c), 16'h0000);
		for (int g = 0; g < 16; g++) codes[4*g +: 4] = 4'h1 << rnd() % 4;
		first = codes;
		@(posedge clk);
		#1;
		codes = ~first;
		for (int c = 8'hDD; c <= 8'hDF; c++) rc(8'(c), pw(8'(c), first));
		pulse(4'h1);
		for (int c = 8'hDD; c <= 8'hDF; c++) rc(8'(c), 16'h0000);
		$display("test phase codes done");
		wd = 16'(rnd());
		host.xfer(1'b1, flr_pkg::CMD_DATE_WORD, wd, d);
		rc(flr_pkg::CMD_DATE_WORD, wd);
		rc(flr_pkg::CMD_SEC_LOWER, 16'h0000);
		host.xfer(1'b1, flr_pkg::CMD_SEC_UPPER, 16'hFFFF, d);
		rc(flr_pkg::CMD_SEC_UPPER, 16'h00FF);
		host.xfer(1'b1, flr_pkg::CMD_SEC_LOWER, ~wd, d);
		rc(flr_pkg::CMD_SEC_LOWER, ~wd);
		host.xfer(1'b1, flr_pkg::CMD_DATE_WORD, wd, d);
		rc(flr_pkg::CMD_SEC_UPPER, 16'h0000);
		rc(flr_pkg::CMD_SEC_LOWER, 16'h0000);
		host.xfer(1'b1, flr_pkg::CMD_CUR_RAIL1, 16'hFFFF, d);
		rc(flr_pkg::CMD_CUR_RAIL1, 16'h0000);
		pulse(4'h2);
		chk({15'h0000, run}, 16'h0001);
		repeat (5 * STEP) @(posedge clk);
		host.xfer(1'b0, flr_pkg::CMD_SEC_LOWER, 16'h0000, d);
		chk(16'(d >= 16'h4 && d <= 16'h6), 16'h0001);
		host.xfer(1'b1, flr_pkg::CMD_DATE_WORD, ~wd, d);
		rc(flr_pkg::CMD_DATE_WORD, wd);
		host.xfer(1'b0, flr_pkg::CMD_SEC_LOWER, 16'h0000, d);
		chk(16'(d <= 16'h1), 16'h0001);
		nvm_d = ~wd;
		pulse(4'h8);
		rc(flr_pkg::CMD_DATE_WORD, ~wd);
		$display("test fault time done");
		for (int k = 0; k < 4; k++) m[k] = 10'(rnd());
		snap = m;
		repeat (3 * STEP) @(posedge clk);
		host.xfer(1'b0, flr_pkg::CMD_SEC_LOWER, 16'h0000, e);
		pulse(4'h4);
		for (int k = 0; k < 4; k++) m[k] = ~snap[k];
		host.xfer(1'b0, flr_pkg::CMD_SEC_LOWER, 16'h0000, f);
		chk(16'(f - e <= 16'h0001), 16'h0001);
		chk({15'h0000, ffs}, 16'h0001);
		repeat (3 * STEP) @(posedge clk);
		pulse(4'h4);
		rc(flr_pkg::CMD_SEC_LOWER, f);
		for (int k = 0; k < 4; k++) rc(8'(8'hE3 + k), {6'h00, snap[k]});
		pulse(4'h1);
		chk({14'h0000, run, ffs}, 16'h0000);
		rc(flr_pkg::CMD_CUR_RAIL1, 16'h0000);
		$display("test snapshots done");
		finish_test();
	end
endmodule

// *** pkg/flr_pkg.sv ***
// Package for the fault log register bank: command codes, field layout, timing counts.
// Assumes a 100 MHz system clock and 16-bit register words.
package flr_pkg;
	localparam logic [7:0]  CMD_PHASE_R1_HI_A = 8'hDD;
	localparam logic [7:0]  CMD_PHASE_R1_HI_B = 8'hDE;
	localparam logic [7:0]  CMD_PHASE_R2_LO   = 8'hDF;
	localparam logic [7:0]  CMD_DATE_WORD     = 8'hE0;
	localparam logic [7:0]  CMD_SEC_UPPER     = 8'hE1;
	localparam logic [7:0]  CMD_SEC_LOWER     = 8'hE2;
	localparam logic [7:0]  CMD_CUR_RAIL1     = 8'hE3;
	localparam logic [7:0]  CMD_CUR_RAIL2     = 8'hE4;
	localparam logic [7:0]  CMD_VOLT_RAIL1    = 8'hE5;
	localparam logic [7:0]  CMD_VOLT_RAIL2    = 8'hE6;
	localparam int          CODE_W            = 4;
	localparam int          SNAP_W            = 10;
	localparam int          SEC_UPPER_W       = 8;
	localparam int          SEC_LOWER_W       = 16;
	localparam int          SEC_W             = 24;
	localparam logic [3:0]  CODE_NONE         = 4'h0;
	localparam logic [3:0]  CODE_VIN_SW_SHORT = 4'h1;
	localparam logic [3:0]  CODE_CUR_LIMIT    = 4'h2;
	localparam logic [3:0]  CODE_OVER_TEMP    = 4'h4;
	localparam logic [3:0]  CODE_SW_GND_SHORT = 4'h8;
	localparam logic [15:0] DATE_RESET        = 16'h0000;
	localparam logic [23:0] SEC_RESET         = 24'h000000;
	localparam int          CLK_HZ            = 100_000_000;
	localparam int          STEP_TIME_S       = 1;
	localparam int          STEP_CYCLES       = CLK_HZ * STEP_TIME_S;
endpackage

// *** src/flr_fault_log.sv ***
// Fault log register bank: per-phase codes, fault time, first-fault snapshots.
// Assumes a command decoder on the system clock presents a command code with
// one-cycle read and write strobes; fault inputs come from the same clock domain.

// Function
// - Phase codes are 4-bit one-hot fault types
// - Rail 1 phases 9-12 in one word
// - Phases 13-16 word doubles as rail 2 8-5
// - Rail 2 phases 4-1 in one word
// - Phase codes clear on device shutdown
// - Time is date, upper 8, lower 16
// - Accumulator steps once per second
// - Date write clears both accumulator registers
// - Date write rejected once accumulator runs
// - Accumulator starts during start-up
// - First fault time kept in time cells
// - Upper-bits register top byte reads zero
// - Current snapshots 10-bit, upper bits zero
// - Voltage snapshots 10-bit in low bits
module flr_fault_log #(
	parameter int STEP_CYCLES = flr_pkg::STEP_CYCLES
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_shutdown,
	input  wire logic        i_startup,
	input  wire logic        i_fault_event,
	input  wire logic [63:0] i_phase_codes,
	input  wire logic [9:0]  i_rail1_current_monitor,
	input  wire logic [9:0]  i_rail2_current_monitor,
	input  wire logic [9:0]  i_rail1_diff_voltage,
	input  wire logic [9:0]  i_rail2_diff_voltage,
	input  wire logic [7:0]  i_cmd,
	input  wire logic        i_wr_stb,
	input  wire logic        i_rd_stb,
	input  wire logic [15:0] i_wr_data,
	input  wire logic        i_nvm_date_load,
	input  wire logic [15:0] i_nvm_date,
	output logic      [15:0] o_rd_data,
	output logic             o_rd_valid,
	output logic             o_wr_reject,
	output logic             o_acc_running,
	output logic             o_first_fault_seen
);
	logic        rst_sync1_reg;
	logic        rst_sync2_reg;
	logic        rst_n;
	logic [63:0] codes_q;
	logic [15:0] date_reg;
	logic [23:0] sec_reg;
	logic [23:0] sec_next;
	logic [31:0] tick_cnt_reg;
	logic        tick;
	logic        running_reg;
	logic        first_seen_reg;
	logic [23:0] fault_sec_reg;
	logic [9:0]  cur1_reg;
	logic [9:0]  cur2_reg;
	logic [9:0]  volt1_reg;
	logic [9:0]  volt2_reg;
	logic        date_wr;
	logic        cmd_known;
	logic [15:0] rd_mux;
	logic        sec_upper_wr;
	logic        sec_lower_wr;
	logic        wr_accept;
	logic        fault_capture;
	logic [23:0] time_view;
	logic [3:0]  phase9_fault_code;
	logic [3:0]  phase10_fault_code;
	logic [3:0]  phase11_fault_code;
	logic [3:0]  phase12_fault_code;
	logic [3:0]  phase13_shared_fault_code;
	logic [3:0]  phase14_shared_fault_code;
	logic [3:0]  phase15_shared_fault_code;
	logic [3:0]  phase16_shared_fault_code;
	logic [3:0]  rail2_phase4_fault_code;
	logic [3:0]  rail2_phase3_fault_code;
	logic [3:0]  rail2_phase2_fault_code;
	logic [3:0]  rail2_phase1_fault_code;
	logic [15:0] word_r1_hi_a;
	logic [15:0] word_r1_hi_b;
	logic [15:0] word_r2_lo;

	localparam logic [31:0] STEP_LAST = 32'(STEP_CYCLES - 1);

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_sync1_reg <= 1'b0;
			rst_sync2_reg <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_sync2_reg <= rst_sync1_reg;
		end
	end
	assign rst_n = rst_sync2_reg;

	// Sixteen phase cells: 0-3 rail 2 phases 1-4, 8-15 rail 1 phases 9-16; 4-7 are not reported
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_phase
			flr_phase_code u_cell (
				.i_sys_clk (i_sys_clk),
				.i_rst_n   (rst_n),
				.i_clear   (i_shutdown),
				.i_code    (i_phase_codes[g*4 +: 4]),
				.o_code    (codes_q[g*4 +: 4])
			);
		end
	endgenerate

	// Cells 12 to 15 carry rail 2 phases 8 to 5 when those outputs drive rail 2
	assign phase9_fault_code         = codes_q[35:32];
	assign phase10_fault_code        = codes_q[39:36];
	assign phase11_fault_code        = codes_q[43:40];
	assign phase12_fault_code        = codes_q[47:44];
	assign phase13_shared_fault_code = codes_q[51:48];
	assign phase14_shared_fault_code = codes_q[55:52];
	assign phase15_shared_fault_code = codes_q[59:56];
	assign phase16_shared_fault_code = codes_q[63:60];
	assign rail2_phase4_fault_code   = codes_q[15:12];
	assign rail2_phase3_fault_code   = codes_q[11:8];
	assign rail2_phase2_fault_code   = codes_q[7:4];
	assign rail2_phase1_fault_code   = codes_q[3:0];

	assign word_r1_hi_a = {phase9_fault_code, phase10_fault_code, phase11_fault_code, phase12_fault_code};
	assign word_r1_hi_b = {phase13_shared_fault_code, phase14_shared_fault_code, phase15_shared_fault_code,
		phase16_shared_fault_code};
	assign word_r2_lo   = {rail2_phase4_fault_code, rail2_phase3_fault_code, rail2_phase2_fault_code,
		rail2_phase1_fault_code};

	assign date_wr       = i_wr_stb && (i_cmd == flr_pkg::CMD_DATE_WORD);
	assign sec_upper_wr  = i_wr_stb && (i_cmd == flr_pkg::CMD_SEC_UPPER);
	assign sec_lower_wr  = i_wr_stb && (i_cmd == flr_pkg::CMD_SEC_LOWER);
	assign fault_capture = i_fault_event && !first_seen_reg && !i_shutdown;

	// Only the date word and the time cells take bus writes; the date word locks once the accumulator runs
	always_comb begin
		wr_accept = 1'b0;
		case (i_cmd)
			flr_pkg::CMD_DATE_WORD: wr_accept = !running_reg;
			flr_pkg::CMD_SEC_UPPER,
			flr_pkg::CMD_SEC_LOWER: wr_accept = 1'b1;
			default: wr_accept = 1'b0;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			running_reg <= 1'b0;
		end else if (i_shutdown) begin
			running_reg <= 1'b0;
		end else if (i_startup) begin
			running_reg <= 1'b1;
		end
	end

	// Restarting the divider on a date write keeps the first new second a full second long
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_reg <= '0;
		end else if (!running_reg || date_wr) begin
			tick_cnt_reg <= '0;
		end else if (tick_cnt_reg == STEP_LAST) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
		end
	end
	assign tick = running_reg && (tick_cnt_reg == STEP_LAST);

	// Date word accepts a bus write only while the accumulator is stopped; an NVM date load is taken at any time and wins
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			date_reg <= flr_pkg::DATE_RESET;
		end else if (i_nvm_date_load) begin
			date_reg <= i_nvm_date;
		end else if (date_wr && !running_reg) begin
			date_reg <= i_wr_data;
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_wr_reject <= 1'b0;
		end else begin
			o_wr_reject <= i_wr_stb && !wr_accept;
		end
	end

	always_comb begin
		sec_next = sec_reg;
		if (date_wr) begin
			sec_next = flr_pkg::SEC_RESET;
		end else if (sec_upper_wr) begin
			sec_next = {i_wr_data[7:0], sec_reg[15:0]};
		end else if (sec_lower_wr) begin
			sec_next = {sec_reg[23:16], i_wr_data};
		end else if (tick) begin
			sec_next = sec_reg + 24'h000001;
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_reg <= flr_pkg::SEC_RESET;
		end else begin
			sec_reg <= sec_next;
		end
	end

	// First fault freezes the analogue snapshots and the time until shutdown; a date write zeroes the frozen time
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_seen_reg <= 1'b0;
		end else if (i_shutdown) begin
			first_seen_reg <= 1'b0;
		end else if (i_fault_event) begin
			first_seen_reg <= 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_sec_reg <= flr_pkg::SEC_RESET;
		end else if (date_wr) begin
			fault_sec_reg <= flr_pkg::SEC_RESET;
		end else if (fault_capture) begin
			fault_sec_reg <= sec_reg;
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur1_reg <= '0;
		end else if (i_shutdown) begin
			cur1_reg <= '0;
		end else if (fault_capture) begin
			cur1_reg <= i_rail1_current_monitor;
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur2_reg <= '0;
		end else if (i_shutdown) begin
			cur2_reg <= '0;
		end else if (fault_capture) begin
			cur2_reg <= i_rail2_current_monitor;
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			volt1_reg <= '0;
		end else if (i_shutdown) begin
			volt1_reg <= '0;
		end else if (fault_capture) begin
			volt1_reg <= i_rail1_diff_voltage;
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			volt2_reg <= '0;
		end else if (i_shutdown) begin
			volt2_reg <= '0;
		end else if (fault_capture) begin
			volt2_reg <= i_rail2_diff_voltage;
		end
	end

	// Before a fault the time cells show the live accumulator, after it the frozen record
	always_comb begin
		time_view = sec_reg;
		if (first_seen_reg) begin
			time_view = fault_sec_reg;
		end
	end

	always_comb begin
		rd_mux    = 16'h0000;
		cmd_known = 1'b1;
		case (i_cmd)
			flr_pkg::CMD_PHASE_R1_HI_A: rd_mux = word_r1_hi_a;
			flr_pkg::CMD_PHASE_R1_HI_B: rd_mux = word_r1_hi_b;
			flr_pkg::CMD_PHASE_R2_LO: rd_mux = word_r2_lo;
			flr_pkg::CMD_DATE_WORD: rd_mux = date_reg;
			flr_pkg::CMD_SEC_UPPER: rd_mux = {8'h00, time_view[23:16]};
			flr_pkg::CMD_SEC_LOWER: rd_mux = time_view[15:0];
			flr_pkg::CMD_CUR_RAIL1: rd_mux = {6'h00, cur1_reg};
			flr_pkg::CMD_CUR_RAIL2: rd_mux = {6'h00, cur2_reg};
			flr_pkg::CMD_VOLT_RAIL1: rd_mux = {6'h00, volt1_reg};
			flr_pkg::CMD_VOLT_RAIL2: rd_mux = {6'h00, volt2_reg};
			default: cmd_known = 1'b0;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd_stb;
		end
	end

	// Read data holds until the next read strobe
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rd_data <= 16'h0000;
		end else if (i_rd_stb) begin
			o_rd_data <= cmd_known ? rd_mux : 16'h0000;
		end
	end

	assign o_acc_running      = running_reg;
	assign o_first_fault_seen = first_seen_reg;
endmodule

// *** src/flr_phase_code.sv ***
// One per-phase fault code cell.
// Assumes the fault code arrives already synchronised to the system clock.
module flr_phase_code (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_clear,
	input  wire logic [3:0] i_code,
	output logic      [3:0] o_code
);
	// Only legal one-hot codes are taken; the first code is held until shutdown
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_code <= flr_pkg::CODE_NONE;
		end else if (i_clear) begin
			o_code <= flr_pkg::CODE_NONE;
		end else if (o_code == flr_pkg::CODE_NONE) begin
			case (i_code)
				flr_pkg::CODE_VIN_SW_SHORT,
				flr_pkg::CODE_CUR_LIMIT,
				flr_pkg::CODE_OVER_TEMP,
				flr_pkg::CODE_SW_GND_SHORT: o_code <= i_code;
				default: o_code <= o_code;
			endcase
		end
	end
endmodule
